// >>> verilog/cmd_seq_params.svh
/*
 * constants of the spacecraft command sequencer: word framing, destination codes, depths.
 * assumes inclusion by bare name from the sequencer design file.
 */
`ifndef CMD_SEQ_PARAMS_SVH
`define CMD_SEQ_PARAMS_SVH

`define CS_WORD_W       30
`define CS_START_W      8
`define CS_START_PAT    8'hE2
`define CS_DEST_NONE    3'h0
`define CS_DEST_RELAY   3'h6
`define CS_DEST_LANDER  3'h7
`define CS_FIFO_DEPTH   8
`define CS_MEM_DEPTH    16
`define CS_LANDER_DEPTH 16
`define CS_HAND_RST     30'h0000_0000

`endif

// >>> verilog/cmd_seq_pkg.sv
/*
 * types of the spacecraft command sequencer.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package cmd_seq_pkg;

    // one command word, first bit received is stored
    typedef struct packed {
        logic        stored;
        logic [2:0]  dest;
        logic        quant;
        logic [7:0]  value;
        logic [15:0] tlabel;
        logic        parity;
    } cmd_word_t;

    typedef enum logic [0:0] {
        HUNT = 1'b0,
        DATA = 1'b1
    } frame_state_t;

endpackage : cmd_seq_pkg

// >>> verilog/cmd_sequencer.sv
/*
 * spacecraft command sequencer: word unit on the link clock, fifo, stored command
 * memory, lander hold memory and the execution unit on the system clock.
 * assumes detector bit, sync and lock are synchronous to link_clk and sc_time to clk.
 */
// Functional notes
// - word unit takes bits and sync only while lock is asserted
// - find word start symbol, decode destination of each word
// - check word validity; forward real-time to execution, stored to memory
// - lander commands stay held until a read-out command orders relay
// - real-time commands execute on reaching the fifo head; a stored or lander word with no room blocks them
// - next stored command held in register until label equals spacecraft clock
// - after execution load following stored command, until memory is empty
// - memory read once per stored command, at fetch into holding register
// - parity check on each stored command before execution
// - both quantitative and discrete on/off commands issued
// - spacecraft clock supplies the time label compared against commands
`timescale 1ns/100ps
`include "cmd_seq_params.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module cmd_fifo #(
    parameter int W = `CS_WORD_W,
    parameter int D = `CS_FIFO_DEPTH
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(D);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule : cmd_fifo

////////////////////////////////////////////////////////////////////////////////
module cmd_sequencer
    import cmd_seq_pkg::*;
#(
    parameter int MEM_D    = `CS_MEM_DEPTH,
    parameter int LANDER_D = `CS_LANDER_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        link_clk,
    input  wire logic        det_bit,
    input  wire logic        det_sync,
    input  wire logic        det_lock,
    input  wire logic [15:0] sc_time,
    output logic             exec_valid,
    output cmd_word_t        exec_cmd,
    output logic             exec_on,
    output logic             parity_err,
    output logic             relay_valid,
    output cmd_word_t        relay_cmd,
    output logic             stored_pending,
    output logic             lander_pending
);
    localparam int W   = `CS_WORD_W;
    localparam int SW  = `CS_START_W;
    localparam int MA  = $clog2(MEM_D);
    localparam int LA  = $clog2(LANDER_D);

    ////////////////////////////////////////////////////////////////////////////
    // link domain: word unit
    logic              lrst_meta;
    logic              lrst;
    frame_state_t      fstate;
    logic [W-1:0]      shift;
    logic [$clog2(W):0] bitcnt;
    logic [W-1:0]      hand_word;
    logic              req_tgl;
    logic              ack_tgl;
    logic              ack_meta;
    logic              ack_s;

    wire [W-1:0]  rx_word   = {shift[W-2:0], det_bit};
    cmd_word_t    rx_cmd;
    assign rx_cmd = cmd_word_t'(rx_word);
    wire          start_hit = rx_word[SW-1:0] == `CS_START_PAT;
    wire          word_end  = bitcnt == ($clog2(W)+1)'(W-1);
    // even parity over the word and a real destination make it valid
    wire          word_ok   = ~(^rx_word) && rx_cmd.dest != `CS_DEST_NONE;
    wire          busy      = req_tgl != ack_s;

    always_ff @(posedge link_clk) begin
        lrst_meta <= sys_rst;
        lrst      <= lrst_meta;
        ack_meta  <= ack_tgl;
        ack_s     <= ack_meta;
    end

    always_ff @(posedge link_clk) begin
        if (lrst) begin
            fstate <= HUNT;
            shift  <= '0;
            bitcnt <= '0;
        end else if (!det_lock) begin
            fstate <= HUNT;
            bitcnt <= '0;
        end else if (det_sync) begin
            shift  <= rx_word;
            bitcnt <= (fstate == DATA && !word_end) ? bitcnt + 1'b1 : '0;
            if (fstate == HUNT && start_hit) begin
                fstate <= DATA;
            end else if (fstate == DATA && word_end) begin
                fstate <= HUNT;
            end
        end
    end

    // a word arriving while the previous one is still crossing is lost
    always_ff @(posedge link_clk) begin
        if (lrst) begin
            req_tgl   <= 1'b0;
            hand_word <= `CS_HAND_RST;
        end else if (det_lock && det_sync && fstate == DATA && word_end
                     && word_ok && !busy) begin
            hand_word <= rx_word;
            req_tgl   <= ~req_tgl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain: crossing into the fifo
    logic      req_meta;
    logic      req_s;
    logic      fifo_in_ready;
    logic      head_valid;
    logic      head_ready;
    logic [W-1:0] head_bits;

    wire       in_valid = req_s != ack_tgl;

    always_ff @(posedge clk) begin
        req_meta <= req_tgl;
        req_s    <= req_meta;
    end

    // ack only once the fifo has taken the word, so a full fifo keeps the crossing busy and new link words are lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_tgl <= 1'b0;
        end else if (in_valid && fifo_in_ready) begin
            ack_tgl <= req_s;
        end
    end

    cmd_fifo #(.W(W), .D(`CS_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (hand_word),
        .out_valid (head_valid),
        .out_ready (head_ready),
        .out_data  (head_bits)
    );

    ////////////////////////////////////////////////////////////////////////////
    // dispatch
    cmd_word_t    head;
    assign head = cmd_word_t'(head_bits);

    logic [W-1:0] smem [MEM_D];
    logic [W-1:0] lmem [LANDER_D];
    logic [MA:0]  s_wr;
    logic [MA:0]  s_rd;
    logic [LA:0]  l_wr;
    logic [LA:0]  l_rd;
    logic         readout;
    cmd_word_t    hold;
    logic         hold_valid;

    wire s_full    = (s_wr - s_rd) == (MA+1)'(MEM_D);
    wire l_full    = (l_wr - l_rd) == (LA+1)'(LANDER_D);
    wire s_empty   = s_wr == s_rd;
    wire l_empty   = l_wr == l_rd;
    wire is_lander = head.dest == `CS_DEST_LANDER;
    wire rt_take   = head_valid && !head.stored && !is_lander;
    wire s_push    = head_valid && head.stored && !is_lander && !s_full;
    wire l_push    = head_valid && is_lander && !l_full;
    assign head_ready = rt_take | s_push | l_push;

    // holding register: fetch once, compare, execute or discard
    wire fetch     = !hold_valid && !s_empty;
    wire par_bad   = hold_valid && (^hold);
    wire due       = hold_valid && !par_bad && hold.tlabel == sc_time;
    // real-time takes the execution slot; a due stored command waits for every cycle of rt_take
    wire st_run    = due && !rt_take;
    wire run       = rt_take | st_run;
    cmd_word_t run_cmd;
    assign run_cmd = rt_take ? head : hold;
    wire ro_order  = run && run_cmd.dest == `CS_DEST_RELAY;
    wire l_pop     = readout && !l_empty;

    always_ff @(posedge clk) begin
        if (s_push) begin
            smem[s_wr[MA-1:0]] <= head_bits;
        end
        if (l_push) begin
            lmem[l_wr[LA-1:0]] <= head_bits;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_wr <= '0;
            s_rd <= '0;
            l_wr <= '0;
            l_rd <= '0;
        end else begin
            s_wr <= s_wr + (MA+1)'(s_push);
            s_rd <= s_rd + (MA+1)'(fetch);
            l_wr <= l_wr + (LA+1)'(l_push);
            l_rd <= l_rd + (LA+1)'(l_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_valid <= 1'b0;
            hold       <= cmd_word_t'(`CS_HAND_RST);
        end else if (fetch) begin
            hold_valid <= 1'b1;
            hold       <= cmd_word_t'(smem[s_rd[MA-1:0]]);
        end else if (par_bad || st_run) begin
            hold_valid <= 1'b0;
        end
    end

    // read-out runs until the lander store is drained
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readout <= 1'b0;
        end else if (ro_order) begin
            readout <= 1'b1;
        end else if (l_empty) begin
            readout <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exec_valid  <= 1'b0;
            exec_cmd    <= cmd_word_t'(`CS_HAND_RST);
            exec_on     <= 1'b0;
            parity_err  <= 1'b0;
            relay_valid <= 1'b0;
            relay_cmd   <= cmd_word_t'(`CS_HAND_RST);
        end else begin
            exec_valid  <= run;
            parity_err  <= par_bad;
            relay_valid <= l_pop;
            if (run) begin
                exec_cmd <= run_cmd;
                exec_on  <= !run_cmd.quant && run_cmd.value[0];
            end
            if (l_pop) begin
                relay_cmd <= cmd_word_t'(lmem[l_rd[LA-1:0]]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stored_pending <= 1'b0;
            lander_pending <= 1'b0;
        end else begin
            stored_pending <= !s_empty || hold_valid;
            lander_pending <= !l_empty;
        end
    end
endmodule : cmd_sequencer

`default_nettype wire

// >>> tb/cmd_det_model.sv
/* command detector model: frames words on the link clock.
   assumes a free running link clock from the bench. */
`timescale 1ns/100ps
`default_nettype none
module cmd_det_model (
    input  wire logic link_clk,
    output logic      det_bit,
    output logic      det_sync,
    output logic      det_lock
);
    initial begin
        det_bit = 1'b0;
        det_sync = 1'b0;
        det_lock = 1'b1;
    end
    // start symbol, then 30 bits msb first
    task send(input logic [29:0] w, input logic lock);
        logic [37:0] f;
        int          i;
        f = {8'hE2, w};
        for (i = 37; i >= 0; i--) begin
            @(posedge link_clk);
            det_lock <= lock;
            det_sync <= 1'b1;
            det_bit  <= f[i];
        end
        @(posedge link_clk);
        // released line shows the inverse, never a stale bit
        det_bit  <= ~f[0];
        det_sync <= 1'b0;
        det_lock <= 1'b1;
    endtask : send
endmodule : cmd_det_model
`default_nettype wire

// >>> tb/cmd_sequencer_chk.sv
/* assertions on the sequencer outputs.
   assumes the design package is compiled first. */
`timescale 1ns/100ps
`default_nettype none
module cmd_sequencer_chk
    import cmd_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [15:0] sc_time,
    input wire logic        exec_valid,
    input wire cmd_word_t   exec_cmd,
    input wire logic        exec_on,
    input wire logic        parity_err,
    input wire logic        relay_valid,
    input wire cmd_word_t   relay_cmd,
    input wire logic        stored_pending,
    input wire logic        lander_pending
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_readout;
        exec_valid && exec_cmd.dest == 3'h6 && lander_pending;
    endsequence
    sequence s_stored_exec;
        exec_valid && exec_cmd.stored;
    endsequence
    a_reset_quiet: assert property (
        $fell(sys_rst) |-> !(exec_valid || parity_err || relay_valid || stored_pending))
        else $error("output active after reset");
    a_exec_parity_ok: assert property (
        exec_valid |-> !(^exec_cmd)) else $error("odd parity executed");
    a_exec_dest_ok: assert property (
        exec_valid |-> exec_cmd.dest != 3'h0 && exec_cmd.dest != 3'h7)
        else $error("bad destination executed");
    // one cycle of slack: a real-time command may delay the stored one
    a_label_match: assert property (
        s_stored_exec |-> exec_cmd.tlabel == $past(sc_time) || exec_cmd.tlabel == $past(sc_time, 2))
        else $error("stored command off its label");
    a_exec_on_rule: assert property (
        exec_valid |-> exec_on == (!exec_cmd.quant && exec_cmd.value[0]))
        else $error("on level wrong");
    a_stored_held: assert property (
        s_stored_exec |-> $past(stored_pending)) else $error("stored exec from empty");
    a_perr_held: assert property (
        parity_err |-> $past(stored_pending)) else $error("parity error from empty");
    a_relay_lander: assert property (
        relay_valid |-> relay_cmd.dest == 3'h7 && $past(lander_pending))
        else $error("relay without lander word");
    a_readout_relay: assert property (
        s_readout |-> ##[1:4] relay_valid) else $error("read-out not relayed");
endmodule : cmd_sequencer_chk
bind cmd_sequencer cmd_sequencer_chk u_chk (.clk(clk), .sys_rst(sys_rst), .sc_time(sc_time),
    .exec_valid(exec_valid), .exec_cmd(exec_cmd), .exec_on(exec_on), .parity_err(parity_err),
    .relay_valid(relay_valid), .relay_cmd(relay_cmd), .stored_pending(stored_pending),
    .lander_pending(lander_pending));
`default_nettype wire

// >>> tb/spacecraft_command_sequencer_tb.sv
/* self-checking bench of the command sequencer.
   assumes the detector model and checker are compiled with it. */
`timescale 1ns/100ps
`default_nettype none
module spacecraft_command_sequencer_tb import cmd_seq_pkg::*;;
    logic      clk, link_clk, sys_rst, det_bit, det_sync, det_lock;
    logic      exec_valid, exec_on, parity_err, relay_valid, stored_pending, lander_pending;
    logic      [15:0] sc_time;
    cmd_word_t exec_cmd, relay_cmd, last_exec, last_relay, w;
    logic      last_on;
    int        mismatches, total_checks, exec_n, relay_n, perr_n, n;
    cmd_sequencer dut (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .det_bit(det_bit),
        .det_sync(det_sync), .det_lock(det_lock), .sc_time(sc_time), .exec_valid(exec_valid),
        .exec_cmd(exec_cmd), .exec_on(exec_on), .parity_err(parity_err),
        .relay_valid(relay_valid), .relay_cmd(relay_cmd), .stored_pending(stored_pending),
        .lander_pending(lander_pending));
    cmd_det_model det (.link_clk(link_clk), .det_bit(det_bit), .det_sync(det_sync),
        .det_lock(det_lock));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        if (exec_valid === 1'b1) begin
            exec_n++;
            last_exec = exec_cmd;
            last_on = exec_on;
        end
        if (relay_valid === 1'b1) begin
            relay_n++;
            last_relay = relay_cmd;
        end
        if (parity_err === 1'b1) begin
            perr_n++;
        end
    end
    function automatic cmd_word_t mk(logic s, logic [2:0] d, logic q, logic [7:0] v,
                                     logic [15:0] t);
        mk = {s, d, q, v, t, 1'b0};
        mk.parity = ^mk;
    endfunction : mk
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // bounded wait for a count to reach k
    task wait_cnt(input int k, input bit rel);
        int i;
        for (i = 0; i < 100 && (rel ? relay_n : exec_n) < k; i++) @(posedge clk);
    endtask : wait_cnt
    task t_realtime;
        int q;
        for (q = 0; q < 2; q++) begin
            n = exec_n;
            w = mk(1'b0, 3'h2, q[0], 8'h35, 16'h0000);
            det.send(w, 1'b1);
            wait_cnt(n + 1, 1'b0);
            check("rt count", exec_n, n + 1);
            check("rt word", last_exec, w);
            check("rt on", last_on, !q[0]);
        end
        $display("test realtime done");
    endtask : t_realtime
    task t_refuse;
        n = exec_n;
        w = mk(1'b0, 3'h2, 1'b1, 8'h11, 16'h0000);
        det.send(w, 1'b0);
        det.send(w ^ 30'h0000_0001, 1'b1);
        det.send(mk(1'b0, 3'h0, 1'b1, 8'h11, 16'h0000), 1'b1);
        repeat (40) @(posedge clk);
        check("refused count", exec_n, n);
        $display("test refuse done");
    endtask : t_refuse
    task t_stored;
        cmd_word_t s2;
        n = exec_n;
        @(posedge clk);
        sc_time <= 16'h0010;
        w = mk(1'b1, 3'h3, 1'b1, 8'h42, 16'h0020);
        s2 = mk(1'b1, 3'h4, 1'b0, 8'h01, 16'h0030);
        det.send(w, 1'b1);
        det.send(s2, 1'b1);
        repeat (20) @(posedge clk);
        check("held count", exec_n, n);
        check("pending", stored_pending, 1);
        sc_time <= 16'h0020;
        wait_cnt(n + 1, 1'b0);
        check("first stored", last_exec, w);
        @(posedge clk);
        sc_time <= 16'h0030;
        wait_cnt(n + 2, 1'b0);
        check("second stored", last_exec, s2);
        repeat (3) @(posedge clk);
        check("drained", stored_pending, 0);
        check("no parity flag", perr_n, 0);
        $display("test stored done");
    endtask : t_stored
    task t_lander;
        n = relay_n;
        w = mk(1'b1, 3'h7, 1'b1, 8'hA5, 16'h0000);
        det.send(w, 1'b1);
        repeat (20) @(posedge clk);
        check("no relay", relay_n, n);
        check("lander held", lander_pending, 1);
        det.send(mk(1'b0, 3'h6, 1'b0, 8'h00, 16'h0000), 1'b1);
        wait_cnt(n + 1, 1'b1);
        check("relayed", last_relay, w);
        repeat (3) @(posedge clk);
        check("lander empty", lander_pending, 0);
        // real-time lander word is held too; a stored read-out releases it
        w = mk(1'b0, 3'h7, 1'b0, 8'h5A, 16'h0000);
        det.send(w, 1'b1);
        repeat (20) @(posedge clk);
        check("rt lander held", relay_n, n + 1);
        det.send(mk(1'b1, 3'h6, 1'b0, 8'h00, 16'h0030), 1'b1);
        wait_cnt(n + 2, 1'b1);
        check("stored readout", last_relay, w);
        $display("test lander done");
    endtask : t_lander
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #300000;
        mismatches++;
        finish_test();
    end
    initial begin
        sys_rst = 1'b1;
        sc_time = 16'h0000;
        repeat (4) @(posedge link_clk);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge link_clk);
        t_realtime();
        t_refuse();
        t_stored();
        t_lander();
        finish_test();
    end
endmodule : spacecraft_command_sequencer_tb
`default_nettype wire
